// file: test/asfb_bus_master.sv
// register bus master model standing in for the processor
`timescale 1ns/100ps
`default_nettype none
module asfb_bus_master
(
   // clock
   input  wire logic        sys_clk,
   // write channels
   output var  logic [5:0]  awaddr,
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   output var  logic        wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output var  logic        bready,
   // read channels
   output var  logic [5:0]  araddr,
   output var  logic        arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output var  logic        rready,
   // data bus drivers sampled with the read answer
   input  wire logic [15:0] busDataOut,
   input  wire logic        busDataOeN
);
   int hangs = 0;
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // released payload lines show the inverse so stale values cannot pass
   task automatic writeWord(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge sys_clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (awvalid && awready)
         begin
            awvalid <= 1'b0;
            awaddr  <= ~a;
         end
         if (wvalid && wready)
         begin
            wvalid <= 1'b0;
            wdata  <= ~d;
         end
      end
      while (!(bvalid && bready) && n < 100);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 100)
         hangs++;
   endtask
   task automatic readWord(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp,
                           output logic [15:0] bus, output logic oeN);
      int n;
      n = 0;
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (arvalid && arready)
         begin
            arvalid <= 1'b0;
            araddr  <= ~a;
         end
      end
      while (!(rvalid && rready) && n < 100);
      d = rdata;
      resp = rresp;
      bus = busDataOut;
      oeN = busDataOeN;
      rready <= 1'b0;
      if (n >= 100)
         hangs++;
   endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the status flag and bus data path block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import asfb_pkg::*;
   logic                 sys_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 manualClockEnable = 1'b0;
   logic                 manualClockToggle = 1'b0;
   wire logic [5:0]      awaddr, araddr;
   wire logic [31:0]     wdata, rdata;
   wire logic [3:0]      wstrb;
   wire logic [1:0]      bresp, rresp;
   wire logic            awvalid, awready, wvalid, wready, bvalid, bready;
   wire logic            arvalid, arready, rvalid, rready, busDataOeN, runFlag, selectFlag;
   wire logic [15:0]     busDataOut;
   wire logic [7:0]      statusIndicator;
   wire asfb_phase_type  clockPhases;
   int                   errors = 0;
   int                   compares = 0;
   int                   riseA = 0;
   int                   riseQ = 0;
   logic                 prevA = 1'b0;
   logic                 prevQ = 1'b0;
   logic                 selSeen = 1'b0;
   logic [31:0]          rData;
   logic [1:0]           rResp, wResp;
   logic [15:0]          rBus;
   logic                 rOeN;
   always #5 sys_clk = ~sys_clk;
   asfb_top #(.ADDR_W(6)) u_asfb_top (.sys_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .busDataOut, .busDataOeN, .manualClockEnable, .manualClockToggle, .clockPhases, .runFlag,
      .selectFlag, .statusIndicator);
   asfb_bus_master u_master (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .busDataOut, .busDataOeN);
   always @(posedge sys_clk)
   begin
      prevA <= clockPhases.halfRatePhaseA;
      prevQ <= clockPhases.quarterRateClock;
      if (clockPhases.halfRatePhaseA && !prevA)
         riseA <= riseA + 1;
      if (clockPhases.quarterRateClock && !prevQ)
         riseQ <= riseQ + 1;
      // remembers that the select output was seen high during some transfer
      if (selectFlag)
         selSeen <= 1'b1;
   end
   task automatic final_report();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hangCheck();
      if (u_master.hangs != 0)
      begin
         errors++;
         final_report();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
      u_master.writeWord(a, d, s, wResp);
      hangCheck();
   endtask
   task automatic rd(input logic [5:0] a);
      u_master.readWord(a, rData, rResp, rBus, rOeN);
      hangCheck();
   endtask
   // status byte as the flag rules define it, built independently of the design
   function automatic logic [7:0] expStatus(input logic [15:0] ac, input logic [15:0] mq);
      logic az, ao, mz;
      az = (ac == 16'h0000);
      ao = (ac == 16'hFFFF);
      mz = (mq == 16'h0000);
      return {2'b00, ao, az, mz, az & mz, (ao & mq[15]) | (az & ~mq[15]), 1'b0};
   endfunction
   task automatic testReset();
      check({31'h0, busDataOeN}, 32'h1);
      check({16'h0, busDataOut}, 32'h0);
      check({28'h0, clockPhases}, 32'h0);
      check({24'h0, statusIndicator}, {24'h0, expStatus(16'h0, 16'h0)});
      $display("test reset done");
   endtask
   task automatic testFlags();
      logic [15:0] acs [5] = '{16'hFFFF, 16'h0000, 16'h0001, 16'hFFFF, 16'h0000};
      logic [15:0] mqs [5] = '{16'h8000, 16'h1234, 16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 5; i++)
      begin
         wr(6'h00, {16'h0, acs[i]}, 4'h3);
         wr(6'h04, {16'h0, mqs[i]}, 4'h3);
         rd(6'h08);
         check({24'h0, rData[15:8]}, {24'h0, expStatus(acs[i], mqs[i])});
         check({24'h0, statusIndicator}, {24'h0, expStatus(acs[i], mqs[i])});
      end
      check({31'h0, selSeen}, 32'h1);
      $display("test flags done");
   endtask
   task automatic testSignExtend();
      logic [31:0] ds [4] = '{32'h00000080, 32'h00001280, 32'h0000007F, 32'h0000AB55};
      logic [3:0]  ss [4] = '{4'h1, 4'h3, 4'h1, 4'h1};
      logic [15:0] es [4] = '{16'hFF80, 16'h1280, 16'h007F, 16'h0055};
      for (int i = 0; i < 4; i++)
      begin
         wr(i[0] ? 6'h04 : 6'h00, ds[i], ss[i]);
         rd(i[0] ? 6'h04 : 6'h00);
         check({16'h0, rData[15:0]}, {16'h0, es[i]});
         check({15'h0, rOeN, rBus}, {16'h0, es[i]});
      end
      $display("test sign extension done");
   endtask
   task automatic testCounterAndErrors();
      wr(6'h00, 32'h0000FFFF, 4'h3);
      wr(6'h04, 32'h00008000, 4'h3);
      wr(6'h08, 32'h0000002A, 4'h1);
      rd(6'h08);
      check({26'h0, rData[5:0]}, 32'h2A);
      check({16'h0, rBus}, {16'h0, expStatus(16'hFFFF, 16'h8000), 8'h2A});
      @(posedge sys_clk);
      check({14'h0, selectFlag, busDataOeN, busDataOut}, 32'h00010000);
      rd(6'h10);
      check({rResp, rData[29:0]}, {RESP_SLVERR, 30'h0});
      wr(6'h10, 32'h00001234, 4'h3);
      check({30'h0, wResp}, {30'h0, RESP_SLVERR});
      rd(6'h00);
      check({16'h0, rData[15:0]}, 32'h0000FFFF);
      $display("test counter and errors done");
   endtask
   task automatic testNormalize();
      int n;
      wr(6'h08, 32'h0, 4'h1);
      wr(6'h00, 32'h0000F000, 4'h3);
      wr(6'h04, 32'h0, 4'h3);
      wr(6'h0C, 32'h1, 4'h1);
      n = 0;
      while (runFlag !== 1'b0 && n < 200)
      begin
         @(posedge sys_clk);
         n++;
      end
      check({31'h0, n < 200}, 32'h1);
      if (n >= 200)
         final_report();
      rd(6'h00);
      check({16'h0, rData[15:0]}, {16'h0, ACC_NEG_HALF});
      rd(6'h08);
      check({26'h0, rData[5:0]}, 32'h2);
      $display("test normalize done");
   endtask
   task automatic testManual();
      int a0, q0;
      manualClockEnable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(6'h00, 32'h00000400, 4'h3);
      wr(6'h04, 32'h0, 4'h3);
      wr(6'h08, 32'h0, 4'h1);
      wr(6'h0C, 32'h1, 4'h1);
      rd(6'h0C);
      check({28'h0, rData[3], 2'b00, rData[0]}, 32'h9);
      rd(6'h00);
      check({16'h0, rData[15:0]}, 32'h00000400);
      a0 = riseA;
      q0 = riseQ;
      repeat (8)
      begin
         @(posedge sys_clk);
         manualClockToggle <= ~manualClockToggle;
         repeat (5) @(posedge sys_clk);
      end
      check(riseA - a0, 32'h2);
      check(riseQ - q0, 32'h1);
      wr(6'h0C, 32'h2, 4'h1);
      @(posedge sys_clk);
      check({27'h0, runFlag, clockPhases}, 32'h0);
      manualClockEnable <= 1'b0;
      $display("test manual clock done");
   endtask
   initial
   begin
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      testReset();
      testFlags();
      testSignExtend();
      testCounterAndErrors();
      testNormalize();
      testManual();
      final_report();
   end
endmodule
`default_nettype wire

// file: verilog/asfb_pkg.sv
// constants and types shared by the arithmetic status flag and bus data path block
`default_nettype none
package asfb_pkg;
   // register byte offsets on the register bus
   localparam logic [3:0]  OFS_ACC        = 4'h0;
   localparam logic [3:0]  OFS_MQ         = 4'h4;
   localparam logic [3:0]  OFS_SCSR       = 4'h8;
   localparam logic [3:0]  OFS_CTRL       = 4'hC;
   // control register write bits
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_STOP_BIT  = 1;
   // status byte bit positions
   localparam int unsigned SR_ALL_ONES    = 5;
   localparam int unsigned SR_ACC_ZERO    = 4;
   localparam int unsigned SR_MQ_ZERO     = 3;
   localparam int unsigned SR_BOTH_ZERO   = 2;
   localparam int unsigned SR_SINGLE      = 1;
   localparam int unsigned HIGH_LANE      = 8;
   // data values
   localparam logic [15:0] ACC_NEG_HALF   = 16'hC000;
   localparam logic [15:0] WORD_ONES      = 16'hFFFF;
   localparam logic [15:0] WORD_ZERO      = 16'h0000;
   localparam logic [7:0]  BYTE_ONES      = 8'hFF;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [5:0]  SC_RESET       = 6'h00;
   localparam logic [5:0]  SC_ONE         = 6'h01;
   localparam logic [5:0]  SC_NORM_LIMIT  = 6'h1F;
   localparam logic [31:0] WORD32_ZERO    = 32'h00000000;
   // axi4-lite responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef struct packed
   {
      logic quarterRateClock;
      logic halfRatePhaseB;
      logic halfRatePhaseA;
      logic basicClock;
   } asfb_phase_type;

   localparam asfb_phase_type PHASE_IDLE  = 4'h0;

   typedef enum logic [1:0]
   {
      OP_IDLE,
      OP_RUN,
      OP_END
   } asfb_op_type;
endpackage
`default_nettype wire

// file: verilog/asfb_top.sv
// arithmetic status flag detectors, bus data path and minor clock phase generator
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - accumulator at minus one half ends normalize
// - status bit 5 flags accumulator all ones
// - status bit 4 flags accumulator zero
// - status bit 3 flags quotient register zero
// - status bit 2 flags both registers zero
// - status bit 1 flags single precision result
// - low read byte muxes accumulator, quotient, counter
// - idle drivers leave the wired-OR bus alone
// - high read byte shows status with counter
// - low-only writes sign extend into high byte
// - select on explicit access, run on implicit
// - stop resets timing and operation flip-flops
// - end signal controls each operation's final step
// - clock gate stops only in idle phase
// - two offset half-rate phases from basic clock
// - quarter-rate clock is basic clock over four
// - four manual toggles per half-rate interval
// - eight manual toggles per quarter-rate interval
// - bus transfers still answered while manually clocked
module asfb_top
#(
   parameter int unsigned ADDR_W = 6
)
(
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0]       awaddr,
   input  wire logic                    awvalid,
   output wire logic                    awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output wire logic                    wready,
   // axi4-lite write response
   output wire logic [1:0]              bresp,
   output wire logic                    bvalid,
   input  wire logic                    bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]       araddr,
   input  wire logic                    arvalid,
   output wire logic                    arready,
   output wire logic [31:0]             rdata,
   output wire logic [1:0]              rresp,
   output wire logic                    rvalid,
   input  wire logic                    rready,
   // wired-OR data bus drivers
   output wire logic [15:0]             busDataOut,
   output wire logic                    busDataOeN,
   // maintenance switches, asynchronous
   input  wire logic                    manualClockEnable,
   input  wire logic                    manualClockToggle,
   // maintenance indicators
   output wire asfb_pkg::asfb_phase_type clockPhases,
   output wire logic                    runFlag,
   output wire logic                    selectFlag,
   output wire logic [7:0]              statusIndicator
);
   import asfb_pkg::*;

   function automatic logic [7:0] statusByteOf(input logic [15:0] acc, input logic [15:0] mq);
      logic accOnes;
      logic accZero;
      logic mqZero;
      accOnes = (acc == WORD_ONES);
      accZero = (acc == WORD_ZERO);
      mqZero = (mq == WORD_ZERO);
      statusByteOf = BYTE_ZERO;
      statusByteOf[SR_ALL_ONES] = accOnes;
      statusByteOf[SR_ACC_ZERO] = accZero;
      statusByteOf[SR_MQ_ZERO] = mqZero;
      statusByteOf[SR_BOTH_ZERO] = accZero & mqZero;
      statusByteOf[SR_SINGLE] = (accOnes & mq[15]) | (accZero & ~mq[15]);
   endfunction

   // a write with the high lane strobe off replaces the high byte by the sign of the low byte
   function automatic logic [15:0] rxWord(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [7:0] lo;
      lo = s[0] ? d[7:0] : old[7:0];
      rxWord = {(s[1] ? d[15:8] : (lo[7] ? BYTE_ONES : BYTE_ZERO)), lo};
   endfunction

   // register bus state
   logic [ADDR_W-1:0]  awAddr_q;
   logic [31:0]        wData_q;
   logic [3:0]         wStrb_q;
   logic               awHeld_q;
   logic               wHeld_q;
   logic               awready_q;
   logic               wready_q;
   logic               bvalid_q;
   logic [1:0]         bresp_q;
   logic               arready_q;
   logic               rvalid_q;
   logic [31:0]        rdata_q;
   logic [1:0]         rresp_q;
   logic               selectFlag_q;
   logic [15:0]        busDataOut_q;
   logic               busDataOeN_q;
   // data registers and operation state
   logic [15:0]        accumulator_q;
   logic [15:0]        accumulator_d;
   logic [15:0]        multiplier_quotient_q;
   logic [15:0]        multiplier_quotient_d;
   logic [5:0]         step_counter_q;
   logic [5:0]         step_counter_d;
   asfb_op_type        opState_q;
   asfb_op_type        opState_d;
   logic               runFlag_q;
   logic               clockOn_q;
   asfb_phase_type     phases_q;
   asfb_phase_type     phases_d;
   logic [7:0]         statusIndicator_q;
   // maintenance switch synchronisers
   logic               manEnSync1_q;
   logic               manEnSync2_q;
   logic               manTglSync1_q;
   logic               manTglSync2_q;
   logic               manTglSync3_q;

   // register bus handshakes
   wire awTake = awvalid & awready_q;
   wire wTake = wvalid & wready_q;
   wire arTake = arvalid & arready_q;
   wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;
   wire bvalidD = doWrite | (bvalid_q & ~bready);
   wire awHeldD = (awHeld_q | awTake) & ~doWrite;
   wire wHeldD = (wHeld_q | wTake) & ~doWrite;
   wire rvalidD = arTake | (rvalid_q & ~rready);
   wire [ADDR_W-1:0] awAddrD = awTake ? awaddr : awAddr_q;
   wire [31:0] wDataD = wTake ? wdata : wData_q;
   wire [3:0] wStrbD = wTake ? wstrb : wStrb_q;

   // address decode
   wire [3:0] wrOfs = {awAddr_q[3:2], 2'b00};
   wire [3:0] rdOfs = {araddr[3:2], 2'b00};
   wire wrMapped = (awAddr_q >> 4) == '0;
   wire rdMapped = (araddr >> 4) == '0;
   wire wrAcc = doWrite & wrMapped & (wrOfs == OFS_ACC);
   wire wrMq = doWrite & wrMapped & (wrOfs == OFS_MQ);
   wire wrSc = doWrite & wrMapped & (wrOfs == OFS_SCSR) & wStrb_q[0];
   wire wrCtrl = doWrite & wrMapped & (wrOfs == OFS_CTRL) & wStrb_q[0];
   wire startCmd = wrCtrl & wData_q[CTRL_START_BIT];
   wire stopCmd = wrCtrl & wData_q[CTRL_STOP_BIT];

   // read multiplexer: the counter select also places the status byte on the high lane
   wire [7:0] statusByte = statusByteOf(accumulator_q, multiplier_quotient_q);
   wire [7:0] scByte = {2'b00, step_counter_q};
   wire [7:0] rdLow = (rdOfs == OFS_ACC) ? accumulator_q[7:0] :
                      (rdOfs == OFS_MQ)  ? multiplier_quotient_q[7:0] : scByte;
   wire [7:0] rdHigh = (rdOfs == OFS_ACC) ? accumulator_q[15:8] :
                       (rdOfs == OFS_MQ)  ? multiplier_quotient_q[15:8] : statusByte;
   wire [31:0] ctrlWord = {24'h000000, phases_q, manEnSync2_q, clockOn_q, selectFlag_q, runFlag_q};
   wire [31:0] readWord = !rdMapped ? WORD32_ZERO :
                          (rdOfs == OFS_CTRL) ? ctrlWord : {16'h0000, rdHigh, rdLow};
   wire [31:0] rdataD = arTake ? readWord : rdata_q;

   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else
      begin
         awHeld_q <= awHeldD;
         wHeld_q <= wHeldD;
         awready_q <= ~awHeldD & ~bvalidD;
         wready_q <= ~wHeldD & ~bvalidD;
         bvalid_q <= bvalidD;
         bresp_q <= doWrite ? (wrMapped ? RESP_OKAY : RESP_SLVERR) : bresp_q;
      end

   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         awAddr_q <= '0;
         wData_q <= WORD32_ZERO;
         wStrb_q <= 4'h0;
      end
      else
      begin
         awAddr_q <= awAddrD;
         wData_q <= wDataD;
         wStrb_q <= wStrbD;
      end

   // the bus side runs on sys_clk alone, so transfers are answered under manual clocking too
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= WORD32_ZERO;
         rresp_q <= RESP_OKAY;
      end
      else
      begin
         arready_q <= ~rvalidD;
         rvalid_q <= rvalidD;
         rdata_q <= rdataD;
         rresp_q <= arTake ? (rdMapped ? RESP_OKAY : RESP_SLVERR) : rresp_q;
      end

   // drivers carry data only while the answer is on offer, else zero and released
   wire selectD = awTake | arTake | (selectFlag_q & ~((bvalid_q & bready) | (rvalid_q & rready)));
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         busDataOut_q <= WORD_ZERO;
         busDataOeN_q <= 1'b1;
         selectFlag_q <= 1'b0;
      end
      else
      begin
         busDataOut_q <= rvalidD ? rdataD[15:0] : WORD_ZERO;
         busDataOeN_q <= ~rvalidD;
         selectFlag_q <= selectD;
      end

   // maintenance switches pass two flip-flops before use
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         manEnSync1_q <= 1'b0;
         manEnSync2_q <= 1'b0;
         manTglSync1_q <= 1'b0;
         manTglSync2_q <= 1'b0;
         manTglSync3_q <= 1'b0;
      end
      else
      begin
         manEnSync1_q <= manualClockEnable;
         manEnSync2_q <= manEnSync1_q;
         manTglSync1_q <= manualClockToggle;
         manTglSync2_q <= manTglSync1_q;
         manTglSync3_q <= manTglSync2_q;
      end

   // every toggle edge of the manual switch is one smallest clock interval
   wire manEdge = manTglSync2_q ^ manTglSync3_q;
   wire phaseIdle = (phases_q == PHASE_IDLE);
   // once the clock is switched off the phases still run on to the idle state
   wire gateOpen = clockOn_q | ~phaseIdle;
   wire tick = gateOpen & (manEnSync2_q ? manEdge : 1'b1);
   wire phaseARise = tick & ~phases_q.basicClock & ~phases_q.halfRatePhaseA;
   wire step = phaseARise & (opState_q == OP_RUN);

   always_comb
   begin
      phases_d = phases_q;
      if (tick)
      begin
         phases_d.basicClock = ~phases_q.basicClock;
         if (!phases_q.basicClock)
         begin
            phases_d.halfRatePhaseA = ~phases_q.halfRatePhaseA;
         end
         else
         begin
            // phase b follows phase a half a basic period later
            phases_d.halfRatePhaseB = phases_q.halfRatePhaseA;
         end
         if (phaseARise)
         begin
            phases_d.quarterRateClock = ~phases_q.quarterRateClock;
         end
      end
   end

   // normalize sequencing
   wire normalizeEndDetect = (accumulator_q == ACC_NEG_HALF);
   wire normEndCond = normalizeEndDetect | (accumulator_q[15] ^ accumulator_q[14]) |
                      statusByte[SR_BOTH_ZERO] | (step_counter_q == SC_NORM_LIMIT);
   wire normShift = step & ~normEndCond;
   wire stopSig = stopCmd | (opState_q == OP_END);

   always_comb
   begin
      opState_d = opState_q;
      case (opState_q)
         OP_IDLE:
         begin
            if (startCmd)
            begin
               opState_d = OP_RUN;
            end
         end
         OP_RUN:
         begin
            if (stopCmd)
            begin
               opState_d = OP_IDLE;
            end
            else if (step & normEndCond)
            begin
               opState_d = OP_END;
            end
         end
         OP_END:
         begin
            opState_d = OP_IDLE;
         end
         default:
         begin
            opState_d = OP_IDLE;
         end
      endcase
   end

   // a shift step has priority over a register write landing in the same cycle
   always_comb
   begin
      accumulator_d = accumulator_q;
      multiplier_quotient_d = multiplier_quotient_q;
      step_counter_d = step_counter_q;
      if (normShift)
      begin
         {accumulator_d, multiplier_quotient_d} = {accumulator_q[14:0], multiplier_quotient_q, 1'b0};
         step_counter_d = step_counter_q + SC_ONE;
      end
      else
      begin
         if (wrAcc)
         begin
            accumulator_d = rxWord(accumulator_q, wData_q, wStrb_q);
         end
         if (wrMq)
         begin
            multiplier_quotient_d = rxWord(multiplier_quotient_q, wData_q, wStrb_q);
         end
         if (wrSc)
         begin
            step_counter_d = wData_q[5:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         accumulator_q <= WORD_ZERO;
         multiplier_quotient_q <= WORD_ZERO;
         step_counter_q <= SC_RESET;
         statusIndicator_q <= BYTE_ZERO;
      end
      else
      begin
         accumulator_q <= accumulator_d;
         multiplier_quotient_q <= multiplier_quotient_d;
         step_counter_q <= step_counter_d;
         statusIndicator_q <= statusByte;
      end

   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         opState_q <= OP_IDLE;
         runFlag_q <= 1'b0;
         clockOn_q <= 1'b0;
         phases_q <= PHASE_IDLE;
      end
      else
      begin
         opState_q <= opState_d;
         runFlag_q <= (opState_d == OP_RUN);
         clockOn_q <= stopSig ? 1'b0 : (clockOn_q | (startCmd & (opState_q == OP_IDLE)));
         phases_q <= phases_d;
      end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign busDataOut = busDataOut_q;
   assign busDataOeN = busDataOeN_q;
   assign clockPhases = phases_q;
   assign runFlag = runFlag_q;
   assign selectFlag = selectFlag_q;
   assign statusIndicator = statusIndicator_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   wire rdScsr = arTake & rdMapped & (rdOfs == OFS_SCSR);

   a_read_all_ones:
      assert property (rdScsr && accumulator_q == WORD_ONES |=> rdata_q[HIGH_LANE + SR_ALL_ONES])
      else $error("all-ones flag missing on status read");
   a_read_acc_zero:
      assert property (rdScsr |=> rdata_q[HIGH_LANE + SR_ACC_ZERO] == $past(accumulator_q == WORD_ZERO))
      else $error("accumulator zero flag wrong");
   a_read_mq_zero:
      assert property (rdScsr |=> rdata_q[HIGH_LANE + SR_MQ_ZERO] == $past(multiplier_quotient_q == WORD_ZERO))
      else $error("quotient zero flag wrong");
   a_both_zero_tie:
      assert property (rdScsr |=> rdata_q[HIGH_LANE + SR_BOTH_ZERO] ==
                       (rdata_q[HIGH_LANE + SR_ACC_ZERO] & rdata_q[HIGH_LANE + SR_MQ_ZERO]))
      else $error("both zero flag not the and of the zero flags");
   a_single_prec:
      assert property (rdScsr && accumulator_q == WORD_ZERO && !multiplier_quotient_q[15]
                       |=> rdata_q[HIGH_LANE + SR_SINGLE])
      else $error("single precision flag missing");
   a_sign_extend:
      assert property (wrAcc && wStrb_q[1:0] == 2'b01 && !normShift
                       |=> accumulator_q[15:8] == {8{accumulator_q[7]}})
      else $error("low byte write not sign extended");
   a_bus_release:
      assert property (!rvalid_q |-> busDataOeN_q && busDataOut_q == WORD_ZERO)
      else $error("bus driven while not transmitting");
   a_norm_end_detect:
      assert property (step && accumulator_q == ACC_NEG_HALF |=> opState_q == OP_END ##1 opState_q == OP_IDLE)
      else $error("minus one half did not end normalize");
   a_stop_clears:
      assert property (opState_q == OP_END |=> !runFlag_q && !clockOn_q)
      else $error("stop left run or clock on");
   a_gate_idle:
      assert property (!clockOn_q && phaseIdle |=> phaseIdle)
      else $error("clock restarted with gate closed");
   a_manual_hold:
      assert property (manEnSync2_q && !manEdge |=> $stable(phases_q))
      else $error("phases moved without a manual toggle");
   a_select_set:
      assert property (awTake || arTake |=> selectFlag_q)
      else $error("select not set on explicit access");

   c_norm_end: cover property (opState_q == OP_RUN ##1 opState_q == OP_END);
   c_status_read: cover property (rdScsr ##1 rvalid_q && rready);
   c_manual_step: cover property (manEnSync2_q && manEdge && step);
   c_sign_ext_write: cover property (wrAcc && !wStrb_q[1] && wData_q[7]);
endmodule
`default_nettype wire
